// >>> src/tmroc_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "tmroc_map.svh"
module tmroc_top #(
	parameter int CNT_W = 16
) (
	input wire logic pclk, // APB clock, 50 MHz
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	input wire logic ext_count_clk_pin, // External count input
	input wire logic osc_40mhz_clock, // 40 MHz oscillator
	input wire logic fast_osc_clock, // Fast oscillator
	input wire logic ext_irq0_pin, // Interrupt / cutoff pin
	output tmroc_pkg::tmroc_pins_t pins, // Waveform pins
	output logic [4:0] irq_req, // Match A-D, overflow pulses
	output logic ext_irq0_req // Falling edge pulse
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (CNT_W < 2 || CNT_W > 16) begin : g_chk
		$error("Counter width must be 2 to 16");
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] mode_reg, mode_next; // Run, buffer, cutoff
	tmroc_pkg::tmroc_ctl1_t ctl1_reg, ctl1_next; // Source, clear
	tmroc_pkg::tmroc_actab_t actab_reg, actab_next; // Actions A/B
	tmroc_pkg::tmroc_actcd_t actcd_reg, actcd_next; // Actions C/D
	logic [7:0] ctl2_reg, ctl2_next; // Stop on A match
	logic [5:0] stat_reg, stat_next; // Sticky event flags
	logic [CNT_W-1:0] cnt_reg, cnt_next; // Counter
	logic [CNT_W-1:0] cmp_reg [4]; // Compare A-D
	logic [CNT_W-1:0] cmp_next [4];
	logic [3:0] lvl_reg, lvl_next; // Pin levels
	logic [3:0] oe_reg, oe_next; // Pin drive enables
	logic [4:0] irq_reg, irq_next; // Event pulses
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic irq0_s1, irq0_s2, irq0_s3; // Pin sync and edge
	logic irq0_req_reg, irq0_req_next;

	// ----------------------------------------------------------------
	// Decode and event terms
	// ----------------------------------------------------------------
	logic tick; // Count source event
	logic [9:0] idx; // Register index
	logic acc; // Access phase, first cycle
	logic wr; // Write takes effect
	logic run; // Counting enabled
	logic tick_run; // Counting tick
	logic [3:0] mat; // Compare matches
	logic ovf; // Overflow event
	logic c_to_a, d_to_b; // C/D steer pins A/B
	logic cut; // Forced cutoff active
	logic [31:0] rd; // Read mux
	logic hit; // Address mapped

	assign idx = paddr[11:2];
	assign acc = psel & penable & ~pready_reg;
	assign wr = psel & penable & pready_reg & pwrite & hit;
	assign run = mode_reg[`TMROC_MODE_RUN];
	assign tick_run = tick & run;
	assign c_to_a = ~actcd_reg.gen_c | mode_reg[`TMROC_MODE_BUFC];
	assign d_to_b = ~actcd_reg.gen_d | mode_reg[`TMROC_MODE_BUFD];
	assign cut = mode_reg[`TMROC_MODE_CUTOFF] & ~irq0_s2;

	// Compare logic runs whether or not any pin is enabled
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			mat[i] = tick_run & (cnt_reg == cmp_reg[i]);
		end
		ovf = tick_run & (cnt_reg == '1) &
			~(ctl1_reg.clr_sel & mat[0]);
	end

	// ----------------------------------------------------------------
	// Count source
	// ----------------------------------------------------------------
	tmroc_src u_src (
		.pclk(pclk),
		.presetn(presetn),
		.src_sel(ctl1_reg.src),
		.ext_clk_pin(ext_count_clk_pin),
		.osc40_clk(osc_40mhz_clock),
		.fast_clk(fast_osc_clock),
		.tick(tick)
	);

	// New pin level for a match action; port keeps the level
	function automatic logic act_level(input tmroc_pkg::tmroc_act_t a,
			input logic cur);
		unique case (a)
			tmroc_pkg::TMROC_ACT_PORT: return cur;
			tmroc_pkg::TMROC_ACT_LOW: return 1'b0;
			tmroc_pkg::TMROC_ACT_HIGH: return 1'b1;
			tmroc_pkg::TMROC_ACT_TGL: return ~cur;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Narrow registers sit low; unassigned bits read as documented
	always_comb begin
		rd = 32'h0000_0000;
		hit = (paddr[1:0] == 2'h0);
		unique case (idx)
			`TMROC_IDX_MODE: rd[7:0] = mode_reg;
			`TMROC_IDX_CTL1: rd[7:0] = ctl1_reg;
			`TMROC_IDX_STAT: rd[6:0] = {irq0_s2, stat_reg};
			`TMROC_IDX_ACTAB: rd[7:0] = actab_reg | `TMROC_ACTAB_ONES;
			`TMROC_IDX_ACTCD: rd[7:0] = actcd_reg;
			`TMROC_IDX_COUNT: rd[CNT_W-1:0] = cnt_reg;
			`TMROC_IDX_CTL2: rd[7:0] = ctl2_reg | `TMROC_CTL2_ONES;
			default: begin
				if (idx >= `TMROC_IDX_CMPA && idx <= `TMROC_IDX_CMPD) begin
					rd[CNT_W-1:0] = cmp_reg[idx[1:0]];
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state of the timer and its registers
	// ----------------------------------------------------------------
	// Hardware effects first, software writes after so they win,
	// except sticky flags where a new event beats the clear
	always_comb begin
		mode_next = mode_reg;
		ctl1_next = ctl1_reg;
		actab_next = actab_reg;
		actcd_next = actcd_reg;
		ctl2_next = ctl2_reg;
		cnt_next = cnt_reg;
		cmp_next = cmp_reg;
		lvl_next = lvl_reg;
		irq_next = {ovf, mat};
		irq0_req_next = ~irq0_s2 & irq0_s3;
		// Counting
		if (tick_run) begin
			if (ctl1_reg.clr_sel && mat[0]) begin
				cnt_next = '0;
			end else begin
				cnt_next = CNT_W'(cnt_reg + 1'b1);
			end
		end
		if (mat[0] && ctl2_reg[`TMROC_CTL2_STOPA]) begin
			mode_next[`TMROC_MODE_RUN] = 1'b0;
		end
		// Buffered C/D move into A/B at the A/B match
		if (mat[0] && mode_reg[`TMROC_MODE_BUFC]) begin
			cmp_next[0] = cmp_reg[2];
		end
		if (mat[1] && mode_reg[`TMROC_MODE_BUFD]) begin
			cmp_next[1] = cmp_reg[3];
		end
		// Pin actions; the own register of a pin has priority
		if (mat[2] && c_to_a) begin
			lvl_next[0] = act_level(actcd_reg.act_c, lvl_reg[0]);
		end
		if (mat[3] && d_to_b) begin
			lvl_next[1] = act_level(actcd_reg.act_d, lvl_reg[1]);
		end
		if (mat[0]) begin
			lvl_next[0] = act_level(actab_reg.act_a, lvl_reg[0]);
		end
		if (mat[1]) begin
			lvl_next[1] = act_level(actab_reg.act_b, lvl_reg[1]);
		end
		if (mat[2] && !c_to_a) begin
			lvl_next[2] = act_level(actcd_reg.act_c, lvl_reg[2]);
		end
		if (mat[3] && !d_to_b) begin
			lvl_next[3] = act_level(actcd_reg.act_d, lvl_reg[3]);
		end
		// Sticky flags, write one to clear
		stat_next = stat_reg;
		if (wr && idx == `TMROC_IDX_STAT) begin
			stat_next = stat_reg & ~pwdata[5:0];
		end
		stat_next = stat_next | {irq0_req_next, ovf, mat};
		// Software writes
		if (wr) begin
			unique case (idx)
				`TMROC_IDX_MODE: mode_next = pwdata[7:0];
				`TMROC_IDX_CTL1: begin
					ctl1_next = pwdata[7:0];
					lvl_next = pwdata[3:0];
				end
				`TMROC_IDX_ACTAB: actab_next = pwdata[7:0] &
					`TMROC_ACTAB_WMASK;
				`TMROC_IDX_ACTCD: actcd_next = pwdata[7:0];
				`TMROC_IDX_COUNT: cnt_next = pwdata[CNT_W-1:0];
				`TMROC_IDX_CTL2: ctl2_next = pwdata[7:0] &
					`TMROC_CTL2_WMASK;
				default: begin
					if (idx >= `TMROC_IDX_CMPA && idx <= `TMROC_IDX_CMPD) begin
						cmp_next[idx[1:0]] = pwdata[CNT_W-1:0];
					end
				end
			endcase
		end
		// Each pin drives only when a waveform action is chosen
		oe_next[0] = (actab_next.act_a != tmroc_pkg::TMROC_ACT_PORT);
		oe_next[1] = (actab_next.act_b != tmroc_pkg::TMROC_ACT_PORT);
		oe_next[2] = (actcd_next.act_c != tmroc_pkg::TMROC_ACT_PORT) &
			actcd_next.gen_c & ~mode_next[`TMROC_MODE_BUFC];
		oe_next[3] = (actcd_next.act_d != tmroc_pkg::TMROC_ACT_PORT) &
			actcd_next.gen_d & ~mode_next[`TMROC_MODE_BUFD];
		if (cut) begin
			oe_next = 4'h0;
		end
	end

	// APB answers one cycle into the access phase
	always_comb begin
		pready_next = acc;
		prdata_next = acc ? rd : prdata_reg;
		pslverr_next = acc & ~hit;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= `TMROC_RST_BYTE;
			ctl1_reg <= `TMROC_RST_BYTE;
			actab_reg <= `TMROC_RST_BYTE;
			actcd_reg <= `TMROC_RST_BYTE;
			ctl2_reg <= `TMROC_RST_BYTE;
			stat_reg <= 6'h00;
			cnt_reg <= '0;
			for (int i = 0; i < 4; i++) begin
				cmp_reg[i] <= CNT_W'(`TMROC_RST_CMP);
			end
			lvl_reg <= 4'h0;
			oe_reg <= 4'h0;
			irq_reg <= 5'h00;
			irq0_req_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			irq0_s1 <= 1'b1;
			irq0_s2 <= 1'b1;
			irq0_s3 <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			ctl1_reg <= ctl1_next;
			actab_reg <= actab_next;
			actcd_reg <= actcd_next;
			ctl2_reg <= ctl2_next;
			stat_reg <= stat_next;
			cnt_reg <= cnt_next;
			cmp_reg <= cmp_next;
			lvl_reg <= lvl_next;
			oe_reg <= oe_next;
			irq_reg <= irq_next;
			irq0_req_reg <= irq0_req_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			irq0_s1 <= ext_irq0_pin;
			irq0_s2 <= irq0_s1;
			irq0_s3 <= irq0_s2;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign pins = '{out: lvl_reg, oe: oe_reg};
	assign irq_req = irq_reg;
	assign ext_irq0_req = irq0_req_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_RD_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pwrite && idx == `TMROC_IDX_COUNT && paddr[1:0] == 2'h0
		|=> pready && prdata[CNT_W-1:0] == $past(cnt_reg))
		else $error("Count read returned a stale value");
	AST_WR_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
		wr && idx == `TMROC_IDX_COUNT |=> cnt_reg == $past(pwdata[CNT_W-1:0]))
		else $error("Count write not loaded");
	AST_INIT_LVL: assert property (@(posedge pclk) disable iff (!presetn)
		wr && idx == `TMROC_IDX_CTL1 |=> pins.out == $past(pwdata[3:0]))
		else $error("Initial levels not driven");
	AST_CLR_A: assert property (@(posedge pclk) disable iff (!presetn)
		tick_run && mat[0] && ctl1_reg.clr_sel &&
		!(wr && idx == `TMROC_IDX_COUNT) |=> cnt_reg == '0)
		else $error("Counter not cleared at A match");
	AST_INCR: assert property (@(posedge pclk) disable iff (!presetn)
		tick_run && !(ctl1_reg.clr_sel && mat[0]) &&
		!(wr && idx == `TMROC_IDX_COUNT)
		|=> cnt_reg == CNT_W'($past(cnt_reg) + 1'b1))
		else $error("Counter did not step by one");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!run && !(wr && idx == `TMROC_IDX_COUNT) |=> $stable(cnt_reg))
		else $error("Counter moved while stopped");
	AST_STOP_A: assert property (@(posedge pclk) disable iff (!presetn)
		mat[0] && ctl2_reg[`TMROC_CTL2_STOPA] &&
		!(wr && idx == `TMROC_IDX_MODE) |=> !run ##1 $stable(cnt_reg))
		else $error("Count kept running after A match");
	AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req[0] |-> $past(tick) && $past(cnt_reg == cmp_reg[0]))
		else $error("Match request without a match");
	AST_BUF: assert property (@(posedge pclk) disable iff (!presetn)
		mat[0] && mode_reg[`TMROC_MODE_BUFC] &&
		!(wr && idx[3:2] == 2'h2) |=> cmp_reg[0] == $past(cmp_reg[2]))
		else $error("Buffer not transferred at match");
	AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		mat[0] && actab_reg.act_a == tmroc_pkg::TMROC_ACT_TGL &&
		!(wr && idx == `TMROC_IDX_CTL1) |=> pins.out[0] != $past(pins.out[0]))
		else $error("Pin A did not toggle");
	AST_RSV_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !pwrite && paddr == {`TMROC_IDX_ACTAB, 2'h0} |=> prdata[7])
		else $error("Unassigned bit read as zero");
endmodule

// >>> src/tmroc_map.svh
`ifndef TMROC_MAP_SVH
`define TMROC_MAP_SVH
// Behaviour
// - Count register read returns live count
// - Count register write loads the counter
// - Interrupt pin: port, output cutoff, interrupt
// - Init bits set pin level before match
// - Control one write drives initial levels
// - Three-bit field selects eight count sources
// - Clear select: free run or clear on A
// - A,B general; C,D general when unbuffered
// - Buffered C,D hold next A,B values
// - Action field A: port, low, high, toggle
// - Action field B uses the same coding
// - Unassigned bit reads one, write zero
// - Any pin subset selectable, rest ports
// - Counter runs with all pins disabled
// - C may drive pin A, D pin B
// - Increment per tick, period by clear mode
// - Run bit starts and stops, state held
// - Stop on A match keeps pin levels
// - Match or overflow raises interrupt request

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define TMROC_IDX_MODE 10'h120
`define TMROC_IDX_CTL1 10'h121
`define TMROC_IDX_STAT 10'h122
`define TMROC_IDX_ACTAB 10'h124
`define TMROC_IDX_ACTCD 10'h125
`define TMROC_IDX_COUNT 10'h126
`define TMROC_IDX_CMPA 10'h128
`define TMROC_IDX_CMPD 10'h12B
`define TMROC_IDX_CTL2 10'h130

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMROC_MODE_CUTOFF 0
`define TMROC_MODE_BUFC 2
`define TMROC_MODE_BUFD 3
`define TMROC_MODE_RUN 7
`define TMROC_CTL2_STOPA 5
`define TMROC_STAT_OVF 4
`define TMROC_STAT_IRQ0 5
`define TMROC_STAT_PIN 6

// ----------------------------------------------------------------
// Reset values and fixed read patterns
// ----------------------------------------------------------------
`define TMROC_RST_BYTE 8'h00
`define TMROC_RST_CMP 16'hFFFF
`define TMROC_ACTAB_ONES 8'h80
`define TMROC_ACTAB_WMASK 8'h7F
`define TMROC_CTL2_ONES 8'h18
`define TMROC_CTL2_WMASK 8'hE7

// ----------------------------------------------------------------
// Prescaler taps
// ----------------------------------------------------------------
`define TMROC_DIV_W 5
`define TMROC_TAP_F2 1
`define TMROC_TAP_F4 2
`define TMROC_TAP_F8 3
`define TMROC_TAP_F32 5
`endif

// >>> src/tmroc_pkg.sv
package tmroc_pkg;
	// Match action coding of a pin
	typedef enum logic [1:0] {
		TMROC_ACT_PORT = 2'h0,
		TMROC_ACT_LOW = 2'h1,
		TMROC_ACT_HIGH = 2'h2,
		TMROC_ACT_TGL = 2'h3
	} tmroc_act_t;

	// Count source select coding
	typedef enum logic [2:0] {
		TMROC_SRC_F1 = 3'h0,
		TMROC_SRC_F2 = 3'h1,
		TMROC_SRC_F4 = 3'h2,
		TMROC_SRC_F8 = 3'h3,
		TMROC_SRC_F32 = 3'h4,
		TMROC_SRC_EXT = 3'h5,
		TMROC_SRC_OSC40 = 3'h6,
		TMROC_SRC_FAST = 3'h7
	} tmroc_src_t;

	// Control one layout, msb first
	typedef struct packed {
		logic clr_sel;
		tmroc_src_t src;
		logic [3:0] init;
	} tmroc_ctl1_t;

	// Pin action A/B layout
	typedef struct packed {
		logic unused;
		logic mode_b;
		tmroc_act_t act_b;
		logic in_sw_a;
		logic mode_a;
		tmroc_act_t act_a;
	} tmroc_actab_t;

	// Pin action C/D layout; gen bits 0 route C/D to pins A/B
	typedef struct packed {
		logic gen_d;
		logic mode_d;
		tmroc_act_t act_d;
		logic gen_c;
		logic mode_c;
		tmroc_act_t act_c;
	} tmroc_actcd_t;

	// Waveform pin bundle
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} tmroc_pins_t;
endpackage

// >>> src/tmroc_src.sv
`timescale 1ns/1ps
`include "tmroc_map.svh"
module tmroc_src #(
	parameter int DIV_W = `TMROC_DIV_W
) (
	input wire logic pclk, // System clock, f1
	input wire logic presetn, // Async reset, low
	input wire tmroc_pkg::tmroc_src_t src_sel, // Source select
	input wire logic ext_clk_pin, // External count pin
	input wire logic osc40_clk, // 40 MHz oscillator
	input wire logic fast_clk, // Fast oscillator
	output logic tick // One-cycle count event
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (DIV_W < `TMROC_TAP_F32) begin : g_chk
		$error("Divider too short for the slowest tap");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_reg, div_next; // Free prescaler
	logic [2:0] s1_reg, s2_reg, s3_reg; // Sync stages and edge
	logic tick_reg, tick_next; // Registered event

	// Taps fire when the low bits of the prescaler are all ones
	function automatic logic tap(input logic [DIV_W-1:0] d,
			input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < n; i++) begin
			r = r & d[i];
		end
		return r;
	endfunction

	// Next values; oscillators are sampled as levels, so any
	// source faster than half of pclk aliases and loses edges
	always_comb begin
		div_next = DIV_W'(div_reg + 1'b1);
		unique case (src_sel)
			tmroc_pkg::TMROC_SRC_F1: tick_next = 1'b1;
			tmroc_pkg::TMROC_SRC_F2: tick_next = tap(div_reg,
				`TMROC_TAP_F2);
			tmroc_pkg::TMROC_SRC_F4: tick_next = tap(div_reg,
				`TMROC_TAP_F4);
			tmroc_pkg::TMROC_SRC_F8: tick_next = tap(div_reg,
				`TMROC_TAP_F8);
			tmroc_pkg::TMROC_SRC_F32: tick_next = tap(div_reg,
				`TMROC_TAP_F32);
			tmroc_pkg::TMROC_SRC_EXT: tick_next = s2_reg[0] & ~s3_reg[0];
			tmroc_pkg::TMROC_SRC_OSC40: tick_next = s2_reg[1] & ~s3_reg[1];
			tmroc_pkg::TMROC_SRC_FAST: tick_next = s2_reg[2] & ~s3_reg[2];
		endcase
	end

	// Registers; first sync stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= '0;
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			s1_reg <= {fast_clk, osc40_clk, ext_clk_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// >>> testbench/tmroc_ext.sv
`timescale 1ns/1ps
// ----
// Board side of the waveform pins and the outside count sources
// ----
module tmroc_ext (
	input wire logic pclk, // Bench clock
	input wire tmroc_pkg::tmroc_pins_t pins, // Waveform pins
	output logic [3:0] level, // Resolved wire levels
	output logic ext_clk, // External count signal
	output logic osc40, // Stand-in oscillator
	output logic fast, // Stand-in fast oscillator
	output int period_a // Cycles between pin A changes
);
	logic [3:0] div_cnt; // Divider for the count sources
	logic last_a; // Pin A level one cycle back
	int since; // Cycles since the last pin A change

	// Released pins fall to the port pull-up, never keep old data
	assign level = (pins.oe & pins.out) | ~pins.oe;
	// Sources stay below half of pclk so the sampler sees every edge
	assign ext_clk = div_cnt[1];
	assign osc40 = div_cnt[1];
	// Stand-in only: a real fast source outruns pclk and would alias
	assign fast = div_cnt[2];

	// Divider and pin A interval timer
	always @(posedge pclk) begin
		div_cnt <= div_cnt + 4'h1;
		last_a <= level[0];
		if (level[0] !== last_a) begin
			period_a <= since;
			since <= 1;
		end else begin
			since <= since + 1;
		end
	end

	// Start from a known state
	initial begin
		div_cnt = 4'h0;
		last_a = 1'b1;
		since = 0;
		period_a = 0;
	end
endmodule

// >>> testbench/timer_output_compare_tb.sv
`timescale 1ns/1ps
`include "tmroc_map.svh"
module timer_output_compare_tb;
	localparam logic [9:0] CMPC = `TMROC_IDX_CMPA + 10'h2; // Compare C
	logic pclk, presetn, psel, penable, pwrite; // Bus and reset
	logic [11:0] paddr; // Byte address
	logic [31:0] pwdata, prdata, rdat, save; // Data and results
	logic pready, pslverr, rerr, ext_irq0_pin, ext_irq0_req; // Status
	logic ext_clk, osc40, fast; // Count sources
	logic [4:0] irq_req; // Event pulses
	logic [3:0] level; // Wire levels
	tmroc_pkg::tmroc_pins_t pins; // Waveform pins
	int period_a, mismatches, check_count, n; // Counters
	int pulses_a = 0; // Match A pulses seen on irq_req
	int divs[8] = '{1, 2, 4, 8, 32, 4, 4, 8}; // pclk cycles per tick, per source

	tmroc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_count_clk_pin(ext_clk),
		.osc_40mhz_clock(osc40), .fast_osc_clock(fast),
		.ext_irq0_pin(ext_irq0_pin), .pins(pins), .irq_req(irq_req),
		.ext_irq0_req(ext_irq0_req));
	tmroc_ext board (.pclk(pclk), .pins(pins), .level(level),
		.ext_clk(ext_clk), .osc40(osc40), .fast(fast),
		.period_a(period_a));

	// Count every match A request pulse while it stands
	always @(posedge pclk) begin
		if (irq_req[0] === 1'b1) begin
			pulses_a <= pulses_a + 1;
		end
	end

	// ----
	// Clock and shared tasks
	// ----
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One bus transfer; request held until pready is seen high
	task automatic xfer(input logic wr, input logic [9:0] idx,
		input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		// One wait state: the answer comes on the second access edge
		chk("wait states", 32'h2, k);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		xfer(1'b1, idx, wd);
	endtask

	task automatic rd(input string what, input logic [9:0] idx,
		input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(what, exp, rdat);
	endtask

	// Restart from zero with a new control one value, then run
	task automatic go(input logic [31:0] ctl, input int cyc);
		wr(`TMROC_IDX_MODE, 32'h00);
		wr(`TMROC_IDX_COUNT, 32'h00);
		wr(`TMROC_IDX_CTL1, ctl);
		wr(`TMROC_IDX_MODE, 32'h80);
		repeat (cyc) @(posedge pclk);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run of some 2000 cycles
	initial begin
		#400000;
		mismatches++;
		summarize();
	end

	// ----
	// Test sequence
	// ----
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ext_irq0_pin = 1'b1;
		mismatches = 0;
		check_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("ctl1 reset", `TMROC_IDX_CTL1, 32'h00);
		rd("actab reset", `TMROC_IDX_ACTAB, 32'h80);
		wr(`TMROC_IDX_ACTAB, 32'h1A);
		rd("actab", `TMROC_IDX_ACTAB, 32'h9A);
		wr(10'h123, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rerr});
		// Initial levels land with the write, no counting needed
		wr(`TMROC_IDX_CTL1, 32'h01);
		@(posedge pclk);
		chk("init ab", 32'h1, {30'h0, level[1:0]});
		wr(`TMROC_IDX_CTL1, 32'h02);
		@(posedge pclk);
		chk("init ab", 32'h2, {30'h0, level[1:0]});
		chk("oe ab", 32'h3, {28'h0, pins.oe});
		wr(`TMROC_IDX_COUNT, 32'h1234);
		rd("count", `TMROC_IDX_COUNT, 32'h1234);
		// Toggle on A with clear on A: period is six ticks per source
		wr(`TMROC_IDX_ACTAB, 32'h0B);
		wr(`TMROC_IDX_CMPA, 32'h5);
		for (int i = 0; i < 8; i++) begin
			go({24'h0, 1'b1, i[2:0], 4'h0}, 18 * divs[i] + 40);
			chk("period", 6 * divs[i], period_a);
		end
		// Stop holds the count
		wr(`TMROC_IDX_MODE, 32'h00);
		xfer(1'b0, `TMROC_IDX_COUNT, 32'h0);
		save = rdat;
		repeat (10) @(posedge pclk);
		rd("count held", `TMROC_IDX_COUNT, save);
		// Stop on A match in free run
		wr(`TMROC_IDX_CMPA, 32'hA);
		wr(`TMROC_IDX_CTL2, 32'h20);
		n = pulses_a;
		go(32'h00, 40);
		rd("run cleared", `TMROC_IDX_MODE, 32'h00);
		chk("a match pulses", 32'h1, pulses_a - n);
		chk("pin a kept", 32'h1, {31'h0, level[0]});
		wr(`TMROC_IDX_CTL2, 32'h00);
		// Buffered C feeds A at the A match
		wr(`TMROC_IDX_CMPA, 32'h5);
		wr(CMPC, 32'h9);
		wr(`TMROC_IDX_ACTCD, 32'h00);
		go(32'h80, 20);
		wr(`TMROC_IDX_MODE, 32'h84);
		repeat (80) @(posedge pclk);
		chk("period buf", 32'hA, period_a);
		wr(`TMROC_IDX_MODE, 32'h00);
		rd("cmpa copied", `TMROC_IDX_CMPA, 32'h9);
		// C drives pin A high while A never matches
		wr(`TMROC_IDX_ACTAB, 32'h09);
		wr(`TMROC_IDX_ACTCD, 32'h02);
		wr(`TMROC_IDX_CMPA, 32'hFFFF);
		wr(CMPC, 32'h3);
		go(32'h00, 20);
		wr(`TMROC_IDX_MODE, 32'h00);
		chk("c on pin a", 32'h1, {31'h0, level[0]});
		chk("oe only a", 32'h1, {28'h0, pins.oe});
		// All outputs off, counter still runs as an internal timer
		wr(`TMROC_IDX_ACTAB, 32'h08);
		wr(`TMROC_IDX_ACTCD, 32'h00);
		wr(`TMROC_IDX_MODE, 32'h80);
		chk("oe none", 32'h0, {28'h0, pins.oe});
		xfer(1'b0, `TMROC_IDX_COUNT, 32'h0);
		save = rdat;
		rd("count step", `TMROC_IDX_COUNT, save + 32'h4);
		rd("status", `TMROC_IDX_STAT, 32'h45);
		// Overflow with A, B and D all at the top value
		wr(`TMROC_IDX_COUNT, 32'hFFFC);
		repeat (8) @(posedge pclk);
		wr(`TMROC_IDX_MODE, 32'h00);
		rd("status ovf", `TMROC_IDX_STAT, 32'h5F);
		// Write one clears; stopped, so no new event sets a flag
		wr(`TMROC_IDX_STAT, 32'h3F);
		rd("status clr", `TMROC_IDX_STAT, 32'h40);
		// Cutoff pin releases every driven pin
		wr(`TMROC_IDX_ACTAB, 32'h0B);
		wr(`TMROC_IDX_MODE, 32'h01);
		chk("oe before cut", 32'h1, {28'h0, pins.oe});
		ext_irq0_pin <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (ext_irq0_req !== 1'b1 && n < 10);
		chk("irq0 pulse", 32'h1, {31'h0, ext_irq0_req});
		@(posedge pclk);
		chk("oe cut", 32'h0, {28'h0, pins.oe});
		summarize();
	end
endmodule
